//--- core/aabu_map.svh
// Register offsets, field positions, reset values and opcode constants for the accumulator ALU and branch unit.
`ifndef AABU_MAP_SVH
`define AABU_MAP_SVH
`define AABU_CTRL_OFF     8'h00
`define AABU_ACC_OFF      8'h04
`define AABU_PSW_OFF      8'h08
`define AABU_OPC_OFF      8'h0c
`define AABU_OPND_OFF     8'h10
`define AABU_PC_OFF       8'h14
`define AABU_PRD_OFF      8'h18
`define AABU_RAMD_OFF     8'h1c
`define AABU_STAT_OFF     8'h20
`define AABU_WREG_OFF     8'h40
`define AABU_CTRL_GO_BIT  0
`define AABU_PSW_CY_BIT   7
`define AABU_PSW_AC_BIT   6
`define AABU_PSW_F0_BIT   5
`define AABU_PSW_F1_BIT   4
`define AABU_PSW_BANK_BIT 3
`define AABU_PSW_TF_BIT   2
`define AABU_ACC_RST      8'h00
`define AABU_PC_RST       12'h000
`define AABU_STEP_ONE     8'h01
`define AABU_BCD_SIX      8'h06
`define AABU_BCD_SIXTY    8'h60
`define AABU_OP_SEL_MB0   8'he5
`define AABU_OP_SEL_MB1   8'hf5
`endif

//--- core/aabu_pkg.sv
// Types shared by the accumulator ALU and branch unit.
package aabu_pkg;
	typedef enum logic [1:0] {
		AABU_IDLE = 2'b00,
		AABU_EXEC = 2'b01,
		AABU_DONE = 2'b10
	} aabu_state_t;
	typedef enum logic [3:0] {
		AABU_NOP  = 4'h0,
		AABU_ADD  = 4'h1,
		AABU_ACC_SUM_WITH_CARRY = 4'h2,
		AABU_AND  = 4'h3,
		AABU_OR   = 4'h4,
		AABU_XOR  = 4'h5,
		AABU_INV  = 4'h6,
		AABU_ZERO = 4'h7,
		AABU_DA   = 4'h8,
		AABU_INC  = 4'h9,
		AABU_DEC  = 4'ha,
		AABU_RL   = 4'hb,
		AABU_RLC  = 4'hc,
		AABU_RR   = 4'hd,
		AABU_RRC  = 4'he,
		AABU_SWAP = 4'hf
	} aabu_aluop_t;
endpackage : aabu_pkg

//--- core/aabu_alu_if.sv
// Interface carrying operands and results between the sequencer and the arithmetic unit.
`timescale 1ns/1ps
interface aabu_alu_if;
	aabu_pkg::aabu_aluop_t op;
	logic [7:0]            acc;
	logic [7:0]            operand;
	logic                  carryIn;
	logic                  halfIn;
	logic [7:0]            result;
	logic                  carryOut;
	logic                  halfOut;
	modport ctrl (output op, output acc, output operand, output carryIn, output halfIn,
		input result, input carryOut, input halfOut);
	modport alu (input op, input acc, input operand, input carryIn, input halfIn,
		output result, output carryOut, output halfOut);
endinterface : aabu_alu_if

//--- core/aabu_alu.sv
// Combinational accumulator arithmetic, logic, rotate, swap and decimal adjust.
`timescale 1ns/1ps
`include "aabu_map.svh"
module aabu_alu (
	aabu_alu_if.alu bus
);
	logic [8:0] sum;
	logic [4:0] low;
	logic [8:0] adj;
	always_comb begin
		sum = 9'h000;
		low = 5'h00;
		adj = 9'h000;
		bus.result   = bus.acc;
		bus.carryOut = bus.carryIn;
		bus.halfOut  = bus.halfIn;
		unique case (bus.op)
			aabu_pkg::AABU_ADD, aabu_pkg::AABU_ACC_SUM_WITH_CARRY: begin
				low = {1'b0, bus.acc[3:0]} + {1'b0, bus.operand[3:0]}
					+ {4'h0, bus.op == aabu_pkg::AABU_ACC_SUM_WITH_CARRY && bus.carryIn};
				sum = {1'b0, bus.acc} + {1'b0, bus.operand}
					+ {8'h00, bus.op == aabu_pkg::AABU_ACC_SUM_WITH_CARRY && bus.carryIn};
				bus.result   = sum[7:0];
				bus.carryOut = sum[8];
				bus.halfOut  = low[4];
			end
			aabu_pkg::AABU_AND:  bus.result = bus.acc & bus.operand;
			aabu_pkg::AABU_OR:   bus.result = bus.acc | bus.operand;
			aabu_pkg::AABU_XOR:  bus.result = bus.acc ^ bus.operand;
			aabu_pkg::AABU_INV:  bus.result = ~bus.acc;
			aabu_pkg::AABU_ZERO: bus.result = `AABU_ACC_RST;
			aabu_pkg::AABU_DA: begin
				// Low nibble first, then high nibble; carry only ever gets set, never cleared.
				adj = {1'b0, bus.acc};
				if (bus.halfIn || adj[3:0] > 4'h9)
					adj = adj + {1'b0, `AABU_BCD_SIX};
				if (bus.carryIn || adj[8] || adj[7:4] > 4'h9)
					adj = {1'b1, 8'h00} | ({1'b0, adj[7:0]} + {1'b0, `AABU_BCD_SIXTY});
				bus.result   = adj[7:0];
				bus.carryOut = bus.carryIn | adj[8];
			end
			aabu_pkg::AABU_INC:  bus.result = bus.acc + `AABU_STEP_ONE;
			aabu_pkg::AABU_DEC:  bus.result = bus.acc - `AABU_STEP_ONE;
			aabu_pkg::AABU_RL:   bus.result = {bus.acc[6:0], bus.acc[7]};
			aabu_pkg::AABU_RLC: begin
				bus.result   = {bus.acc[6:0], bus.carryIn};
				bus.carryOut = bus.acc[7];
			end
			aabu_pkg::AABU_RR:   bus.result = {bus.acc[0], bus.acc[7:1]};
			aabu_pkg::AABU_RRC: begin
				bus.result   = {bus.carryIn, bus.acc[7:1]};
				bus.carryOut = bus.acc[0];
			end
			aabu_pkg::AABU_SWAP: bus.result = {bus.acc[3:0], bus.acc[7:4]};
			aabu_pkg::AABU_NOP:  bus.result = bus.acc;
		endcase
	end
endmodule : aabu_alu

//--- core/aabu_cond.sv
// Branch condition selector for the conditional in-page jumps.
`timescale 1ns/1ps
module aabu_cond (
	// Opcode and tested sources
	input  wire logic [7:0] opcode,
	input  wire logic [7:0] acc,
	input  wire logic       carry,
	input  wire logic       userFlagZero,
	input  wire logic       userFlagOne,
	input  wire logic       timerOverflowFlag,
	input  wire logic       testInputZero,
	input  wire logic       testInputOne,
	input  wire logic       intLine,
	// Decision
	output logic            isCond,
	output logic            take
);
	always_comb begin
		isCond = 1'b1;
		take   = 1'b0;
		if (opcode[4:0] == 5'h12)
			take = acc[opcode[7:5]];
		else begin
			unique case (opcode)
				8'hf6: take = carry;
				8'hb6: take = userFlagZero;
				8'h76: take = userFlagOne;
				8'h16: take = timerOverflowFlag;
				8'h36: take = testInputZero;
				8'h56: take = testInputOne;
				8'he6: take = ~carry;
				8'h86: take = ~intLine;
				8'h26: take = ~testInputZero;
				8'h46: take = ~testInputOne;
				8'h96: take = acc != 8'h00;
				8'hc6: take = acc == 8'h00;
				default: isCond = 1'b0;
			endcase
		end
	end
endmodule : aabu_cond

//--- core/aabu_unit.sv
// Accumulator ALU and branch unit with an AXI4-Lite register port.
`timescale 1ns/1ps
`include "aabu_map.svh"
// What this block does
// - Add immediate second byte to accumulator, result into accumulator.
// - Add working register selected by opcode bits 2:0 to accumulator.
// - Indirect add uses working register 0 or 1 as data-memory pointer.
// - Carry-including add forms add carry plus operand to accumulator.
// - AND accumulator with immediate, register or indirect byte.
// - OR accumulator with immediate, register or indirect byte.
// - XOR accumulator with immediate, register or indirect byte.
// - One instruction inverts accumulator, another clears it.
// - Decimal adjust corrects BCD sum; may set carry.
// - Accumulator increment and decrement change value by one.
// - Plain left rotate, bit 7 into bit 0, carry untouched.
// - Left rotate through carry: bit 0 from carry, carry from bit 7.
// - Plain right rotate, bit 0 into bit 7, carry untouched.
// - Right rotate through carry: bit 7 from carry, carry from bit 0.
// - Swap exchanges accumulator nibbles.
// - Decrement register; branch in page if nonzero, else continue.
// - Accumulator-bit branch tests bit chosen by opcode top three bits.
// - Branches on carry, user flags, timer flag set load low PC; else PC+2.
// - Branches on carry clear, interrupt low, test inputs low take when zero.
// - Branch when accumulator nonzero, otherwise skip the instruction.
// - Direct jump: PC[10:8] from opcode top, low byte from operand, bit 11 bank.
// - Indirect page jump loads low PC from program byte at accumulator.
// - Bank flag set by select-bank-1, cleared by select-bank-0.
module aabu_unit (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Tested pins
	input  wire logic        testInputZero,
	input  wire logic        testInputOne,
	input  wire logic        intLine,
	// Status
	output logic             busy
);
	logic [7:0]  accReg;
	logic [7:0]  pswReg;
	logic [7:0]  opcReg;
	logic [7:0]  opndReg;
	logic [7:0]  prdReg;
	logic [7:0]  ramdReg;
	logic [11:0] pcReg;
	logic [7:0]  wregReg [8];
	logic        awHeld;
	logic        wHeld;
	logic [7:0]  awAddrReg;
	logic [31:0] wDataReg;
	logic [3:0]  wStrbReg;
	logic        wrFire;
	logic        goPulse;
	aabu_pkg::aabu_state_t  stateReg;
	aabu_pkg::aabu_aluop_t  aluOp;
	logic [7:0]  operand;
	logic        aluWrite;
	logic        isCond;
	logic        take;
	logic [7:0]  djnzNext;
	logic [11:0] pcNext;
	logic [2:0]  regSel;
	logic        wregHit;
	aabu_alu_if alu ();
	aabu_alu u_alu (
		.bus (alu.alu)
	);
	aabu_cond u_cond (
		.opcode            (opcReg),
		.acc               (accReg),
		.carry             (pswReg[`AABU_PSW_CY_BIT]),
		.userFlagZero      (pswReg[`AABU_PSW_F0_BIT]),
		.userFlagOne       (pswReg[`AABU_PSW_F1_BIT]),
		.timerOverflowFlag (pswReg[`AABU_PSW_TF_BIT]),
		.testInputZero     (testInputZero),
		.testInputOne      (testInputOne),
		.intLine           (intLine),
		.isCond            (isCond),
		.take              (take)
	);
	// Write channel: address and data are latched independently, in either order.
	assign awready = ~awHeld & ~bvalid;
	assign wready  = ~wHeld & ~bvalid;
	assign wrFire  = awHeld & wHeld & ~bvalid;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			awHeld    <= 1'b0;
			wHeld     <= 1'b0;
			bvalid    <= 1'b0;
			awAddrReg <= 8'h00;
			wDataReg  <= 32'h0000_0000;
			wStrbReg  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awHeld    <= 1'b1;
				awAddrReg <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld    <= 1'b1;
				wDataReg <= wdata;
				wStrbReg <= wstrb;
			end
			if (wrFire) begin
				awHeld <= 1'b0;
				wHeld  <= 1'b0;
				bvalid <= 1'b1;
			end else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end
	assign bresp   = 2'b00;
	assign goPulse = wrFire && awAddrReg == `AABU_CTRL_OFF && wStrbReg[0] && wDataReg[`AABU_CTRL_GO_BIT];
	assign regSel  = awAddrReg[4:2];
	assign wregHit = awAddrReg[7:5] == 3'(`AABU_WREG_OFF >> 5) && wStrbReg[0];
	// Opcode decode onto the arithmetic unit; the operand comes from operand byte, register or memory.
	always_comb begin
		aluOp    = aabu_pkg::AABU_NOP;
		operand  = opndReg;
		aluWrite = 1'b1;
		if (opcReg[7:4] inside {4'h6, 4'h7, 4'h5, 4'h4, 4'hd} && opcReg[3])
			operand = wregReg[opcReg[2:0]];
		else if (opcReg[7:4] inside {4'h6, 4'h7, 4'h5, 4'h4, 4'hd} && opcReg[3:1] == 3'b000)
			operand = ramdReg;
		unique case (opcReg[7:4])
			4'h0: aluOp = opcReg == 8'h03 ? aabu_pkg::AABU_ADD : opcReg == 8'h07 ? aabu_pkg::AABU_DEC
				: aabu_pkg::AABU_NOP;
			4'h1: aluOp = opcReg == 8'h13 ? aabu_pkg::AABU_ACC_SUM_WITH_CARRY : opcReg == 8'h17 ? aabu_pkg::AABU_INC
				: aabu_pkg::AABU_NOP;
			4'h2: aluOp = opcReg == 8'h27 ? aabu_pkg::AABU_ZERO : aabu_pkg::AABU_NOP;
			4'h3: aluOp = opcReg == 8'h37 ? aabu_pkg::AABU_INV : aabu_pkg::AABU_NOP;
			4'h4: aluOp = opcReg == 8'h47 ? aabu_pkg::AABU_SWAP
				: opcReg[3] || opcReg[3:1] == 3'b000 || opcReg == 8'h43 ? aabu_pkg::AABU_OR : aabu_pkg::AABU_NOP;
			4'h5: aluOp = opcReg == 8'h57 ? aabu_pkg::AABU_DA
				: opcReg[3] || opcReg[3:1] == 3'b000 || opcReg == 8'h53 ? aabu_pkg::AABU_AND : aabu_pkg::AABU_NOP;
			4'h6: aluOp = opcReg == 8'h67 ? aabu_pkg::AABU_RRC
				: opcReg[3] || opcReg[3:1] == 3'b000 ? aabu_pkg::AABU_ADD : aabu_pkg::AABU_NOP;
			4'h7: aluOp = opcReg == 8'h77 ? aabu_pkg::AABU_RR
				: opcReg[3] || opcReg[3:1] == 3'b000 ? aabu_pkg::AABU_ACC_SUM_WITH_CARRY : aabu_pkg::AABU_NOP;
			4'hd: aluOp = opcReg[3] || opcReg[3:1] == 3'b000 || opcReg == 8'hd3 ? aabu_pkg::AABU_XOR
				: aabu_pkg::AABU_NOP;
			4'he: aluOp = opcReg == 8'he7 ? aabu_pkg::AABU_RL : aabu_pkg::AABU_NOP;
			4'hf: aluOp = opcReg == 8'hf7 ? aabu_pkg::AABU_RLC : aabu_pkg::AABU_NOP;
			default: aluOp = aabu_pkg::AABU_NOP;
		endcase
		if (aluOp == aabu_pkg::AABU_NOP)
			aluWrite = 1'b0;
	end
	assign alu.op      = aluOp;
	assign alu.acc     = accReg;
	assign alu.operand = operand;
	assign alu.carryIn = pswReg[`AABU_PSW_CY_BIT];
	assign alu.halfIn  = pswReg[`AABU_PSW_AC_BIT];
	assign djnzNext    = wregReg[opcReg[2:0]] - `AABU_STEP_ONE;
	// Next program counter for the branch forms; in-page targets keep bits 11:8.
	always_comb begin
		pcNext = pcReg + 12'h001;
		if (opcReg[4:0] == 5'h04)
			pcNext = {pswReg[`AABU_PSW_BANK_BIT], opcReg[7:5], opndReg};
		else if (opcReg == 8'hb3)
			pcNext = {pcReg[11:8], prdReg};
		else if (opcReg[7:3] == 5'b11101)
			pcNext = djnzNext != 8'h00 ? {pcReg[11:8], opndReg} : pcReg + 12'h002;
		else if (isCond)
			pcNext = take ? {pcReg[11:8], opndReg} : pcReg + 12'h002;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			stateReg <= aabu_pkg::AABU_IDLE;
		else begin
			unique case (stateReg)
				aabu_pkg::AABU_IDLE: if (goPulse) stateReg <= aabu_pkg::AABU_EXEC;
				aabu_pkg::AABU_EXEC: stateReg <= aabu_pkg::AABU_DONE;
				aabu_pkg::AABU_DONE: stateReg <= aabu_pkg::AABU_IDLE;
				default: stateReg <= aabu_pkg::AABU_IDLE;
			endcase
		end
	end
	assign busy = stateReg != aabu_pkg::AABU_IDLE;
	// Accumulator and flags; software writes lose to an executing instruction.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			accReg <= `AABU_ACC_RST;
			pswReg <= 8'h00;
		end else if (stateReg == aabu_pkg::AABU_EXEC) begin
			if (aluWrite) begin
				accReg <= alu.result;
				pswReg[`AABU_PSW_CY_BIT] <= alu.carryOut;
				pswReg[`AABU_PSW_AC_BIT] <= alu.halfOut;
			end
			if (opcReg == `AABU_OP_SEL_MB1)
				pswReg[`AABU_PSW_BANK_BIT] <= 1'b1;
			else if (opcReg == `AABU_OP_SEL_MB0)
				pswReg[`AABU_PSW_BANK_BIT] <= 1'b0;
		end else if (wrFire && wStrbReg[0]) begin
			if (awAddrReg == `AABU_ACC_OFF)
				accReg <= wDataReg[7:0];
			if (awAddrReg == `AABU_PSW_OFF)
				pswReg <= wDataReg[7:0];
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			pcReg <= `AABU_PC_RST;
		else if (stateReg == aabu_pkg::AABU_EXEC)
			pcReg <= pcNext;
		else if (wrFire && awAddrReg == `AABU_PC_OFF && wStrbReg[0])
			pcReg <= {wDataReg[11:8] & {4{wStrbReg[1]}} | pcReg[11:8] & {4{~wStrbReg[1]}}, wDataReg[7:0]};
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			opcReg  <= 8'h00;
			opndReg <= 8'h00;
			prdReg  <= 8'h00;
			ramdReg <= 8'h00;
		end else if (wrFire && wStrbReg[0] && stateReg == aabu_pkg::AABU_IDLE) begin
			if (awAddrReg == `AABU_OPC_OFF)
				opcReg <= wDataReg[7:0];
			if (awAddrReg == `AABU_OPND_OFF)
				opndReg <= wDataReg[7:0];
			if (awAddrReg == `AABU_PRD_OFF)
				prdReg <= wDataReg[7:0];
			if (awAddrReg == `AABU_RAMD_OFF)
				ramdReg <= wDataReg[7:0];
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_wreg
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst)
					wregReg[gi] <= 8'h00;
				else if (stateReg == aabu_pkg::AABU_EXEC && opcReg[7:3] == 5'b11101 && opcReg[2:0] == 3'(gi))
					wregReg[gi] <= djnzNext;
				else if (wrFire && wregHit && regSel == 3'(gi))
					wregReg[gi] <= wDataReg[7:0];
			end
		end
	endgenerate
	// Read channel: one-cycle answer, unmapped addresses read zero with OKAY.
	assign arready = ~rvalid;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= 32'h0000_0000;
			if (araddr[7:5] == 3'(`AABU_WREG_OFF >> 5))
				rdata <= {24'h000000, wregReg[araddr[4:2]]};
			else unique case (araddr)
				`AABU_ACC_OFF:  rdata <= {24'h000000, accReg};
				`AABU_PSW_OFF:  rdata <= {24'h000000, pswReg};
				`AABU_OPC_OFF:  rdata <= {24'h000000, opcReg};
				`AABU_OPND_OFF: rdata <= {24'h000000, opndReg};
				`AABU_PC_OFF:   rdata <= {20'h00000, pcReg};
				`AABU_PRD_OFF:  rdata <= {24'h000000, prdReg};
				`AABU_RAMD_OFF: rdata <= {24'h000000, ramdReg};
				`AABU_STAT_OFF: rdata <= {31'h00000000, busy};
				default:        rdata <= 32'h0000_0000;
			endcase
		end else if (rvalid && rready)
			rvalid <= 1'b0;
	end
	assign rresp = 2'b00;
	sequence execSeq;
		stateReg == aabu_pkg::AABU_EXEC;
	endsequence
	andImm_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'h53 |=> accReg == ($past(accReg) & $past(opndReg)))
		else $error("and result wrong");
	addCarry_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'h13 |=> accReg == 8'($past(accReg) + $past(opndReg) + $past(pswReg[7])))
		else $error("add with carry wrong");
	swapNib_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'h47 |=> accReg == {$past(accReg[3:0]), $past(accReg[7:4])})
		else $error("swap wrong");
	rotCarry_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'hf7 |=> pswReg[7] == $past(accReg[7]) && accReg[0] == $past(pswReg[7]))
		else $error("rotate through carry wrong");
	rotPlain_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'h77 |=> accReg[7] == $past(accReg[0]) && $stable(pswReg))
		else $error("plain rotate wrong");
	jumpSkip_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'hf6 and !pswReg[7] |=> pcReg == 12'($past(pcReg) + 12'h002))
		else $error("skip not two");
	directJump_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg[4:0] == 5'h04 |=> pcReg == {$past(pswReg[3]), $past(opcReg[7:5]), $past(opndReg)})
		else $error("direct jump wrong");
	bankSet_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'hf5 |=> pswReg[3])
		else $error("bank flag not set");
	goExec_a: assert property (@(posedge core_clk) disable iff (rst)
		goPulse and stateReg == aabu_pkg::AABU_IDLE |=> execSeq ##1 stateReg == aabu_pkg::AABU_DONE)
		else $error("sequencer stuck");
	addImm_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'h03 |=> accReg == 8'($past(accReg) + $past(opndReg)))
		else $error("immediate add wrong");
	orImm_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'h43 |=> accReg == ($past(accReg) | $past(opndReg)))
		else $error("or result wrong");
	xorImm_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'hd3 |=> accReg == ($past(accReg) ^ $past(opndReg)))
		else $error("xor result wrong");
	invAcc_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'h37 |=> accReg == ~$past(accReg))
		else $error("invert wrong");
	incAcc_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'h17 |=> accReg == 8'($past(accReg) + 8'h01))
		else $error("increment wrong");
	rotLeft_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'he7 |=> accReg == {$past(accReg[6:0]), $past(accReg[7])} && $stable(pswReg))
		else $error("plain left rotate wrong");
	rotRight_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'h67 |=> pswReg[7] == $past(accReg[0]) && accReg[7] == $past(pswReg[7]))
		else $error("right rotate through carry wrong");
	pageJump_a: assert property (@(posedge core_clk) disable iff (rst)
		execSeq and opcReg == 8'hb3 |=> pcReg == {$past(pcReg[11:8]), $past(prdReg)})
		else $error("indirect page jump wrong");
endmodule : aabu_unit

//--- sim/accumulator_alu_branch_unit_tb_top.sv
// Self-checking testbench for the accumulator ALU and branch unit.
`timescale 1ns/1ps
`include "aabu_map.svh"
module accumulator_alu_branch_unit_tb_top;
	typedef struct packed {
		logic [7:0]  opc, opnd, acc, psw, src;
		logic [2:0]  pins;
		logic [7:0]  eAcc, ePsw;
		logic [11:0] ePc;
	} aabu_row_t;
	localparam int          NROWS    = 46;
	localparam logic [11:0] PC_START = 12'h205;
	logic        core_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, testInputZero, testInputOne, intLine, busy;
	logic [7:0]  awaddr, araddr;
	logic [2:0]  awprot, arprot;
	logic [3:0]  wstrb;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp;
	int          fails, check_count;
	// Operands go to the working register, the data byte and the program byte alike.
	aabu_row_t rows [NROWS] = '{
		'{8'h03, 8'h3a, 8'h4c, 8'h00, 8'h00, 3'd0, 8'h86, 8'h40, 12'h206},
		'{8'h6b, 8'h00, 8'h20, 8'h00, 8'hf0, 3'd0, 8'h10, 8'h80, 12'h206},
		'{8'h61, 8'h00, 8'hff, 8'h00, 8'h01, 3'd0, 8'h00, 8'hc0, 12'h206},
		'{8'h13, 8'h0f, 8'h00, 8'h80, 8'h00, 3'd0, 8'h10, 8'h40, 12'h206},
		'{8'h7f, 8'h00, 8'h80, 8'h80, 8'h7f, 3'd0, 8'h00, 8'hc0, 12'h206},
		'{8'h70, 8'h00, 8'h22, 8'h00, 8'h11, 3'd0, 8'h33, 8'h00, 12'h206},
		'{8'h53, 8'h0f, 8'h3c, 8'hc0, 8'h00, 3'd0, 8'h0c, 8'hc0, 12'h206},
		'{8'h5d, 8'h00, 8'h3c, 8'h00, 8'hf0, 3'd0, 8'h30, 8'h00, 12'h206},
		'{8'h50, 8'h00, 8'hff, 8'h00, 8'h55, 3'd0, 8'h55, 8'h00, 12'h206},
		'{8'h43, 8'h0f, 8'h30, 8'h00, 8'h00, 3'd0, 8'h3f, 8'h00, 12'h206},
		'{8'h4a, 8'h00, 8'h10, 8'h00, 8'h81, 3'd0, 8'h91, 8'h00, 12'h206},
		'{8'h41, 8'h00, 8'h01, 8'h00, 8'h02, 3'd0, 8'h03, 8'h00, 12'h206},
		'{8'hd3, 8'hff, 8'h5a, 8'h00, 8'h00, 3'd0, 8'ha5, 8'h00, 12'h206},
		'{8'hde, 8'h00, 8'hff, 8'h00, 8'h0f, 3'd0, 8'hf0, 8'h00, 12'h206},
		'{8'hd1, 8'h00, 8'haa, 8'h00, 8'haa, 3'd0, 8'h00, 8'h00, 12'h206},
		'{8'h37, 8'h00, 8'h5a, 8'h80, 8'h00, 3'd0, 8'ha5, 8'h80, 12'h206},
		'{8'h27, 8'h00, 8'h5a, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h206},
		'{8'h57, 8'h00, 8'ha5, 8'h00, 8'h00, 3'd0, 8'h05, 8'h80, 12'h206},
		'{8'h17, 8'h00, 8'hff, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h206},
		'{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 3'd0, 8'hff, 8'h00, 12'h206},
		'{8'he7, 8'h00, 8'h81, 8'h00, 8'h00, 3'd0, 8'h03, 8'h00, 12'h206},
		'{8'hf7, 8'h00, 8'h81, 8'h00, 8'h00, 3'd0, 8'h02, 8'h80, 12'h206},
		'{8'h77, 8'h00, 8'h81, 8'h80, 8'h00, 3'd0, 8'hc0, 8'h80, 12'h206},
		'{8'h67, 8'h00, 8'h02, 8'h80, 8'h00, 3'd0, 8'h81, 8'h00, 12'h206},
		'{8'h47, 8'h00, 8'h3c, 8'h00, 8'h00, 3'd0, 8'hc3, 8'h00, 12'h206},
		'{8'hec, 8'h40, 8'h11, 8'h00, 8'h02, 3'd0, 8'h11, 8'h00, 12'h240},
		'{8'hb2, 8'h77, 8'h20, 8'h00, 8'h00, 3'd0, 8'h20, 8'h00, 12'h277},
		'{8'hb2, 8'h77, 8'hdf, 8'h00, 8'h00, 3'd0, 8'hdf, 8'h00, 12'h207},
		'{8'hf6, 8'h31, 8'h00, 8'h80, 8'h00, 3'd0, 8'h00, 8'h80, 12'h231},
		'{8'hf6, 8'h31, 8'h00, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h207},
		'{8'hb6, 8'h32, 8'h00, 8'h20, 8'h00, 3'd0, 8'h00, 8'h20, 12'h232},
		'{8'h76, 8'h33, 8'h00, 8'h10, 8'h00, 3'd0, 8'h00, 8'h10, 12'h233},
		'{8'h16, 8'h34, 8'h00, 8'h04, 8'h00, 3'd0, 8'h00, 8'h04, 12'h234},
		'{8'he6, 8'h35, 8'h00, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h235},
		'{8'h86, 8'h36, 8'h00, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h236},
		'{8'h86, 8'h36, 8'h00, 8'h00, 8'h00, 3'd4, 8'h00, 8'h00, 12'h207},
		'{8'h26, 8'h37, 8'h00, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h237},
		'{8'h26, 8'h37, 8'h00, 8'h00, 8'h00, 3'd1, 8'h00, 8'h00, 12'h207},
		'{8'h46, 8'h38, 8'h00, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h238},
		'{8'h96, 8'h39, 8'h01, 8'h00, 8'h00, 3'd0, 8'h01, 8'h00, 12'h239},
		'{8'h96, 8'h39, 8'h00, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h207},
		'{8'h64, 8'h9a, 8'h00, 8'h08, 8'h00, 3'd0, 8'h00, 8'h08, 12'hb9a},
		'{8'hb3, 8'h00, 8'h07, 8'h00, 8'h5c, 3'd0, 8'h07, 8'h00, 12'h25c},
		'{8'h36, 8'h3a, 8'h00, 8'h00, 8'h00, 3'd1, 8'h00, 8'h00, 12'h23a},
		'{8'h56, 8'h3b, 8'h00, 8'h00, 8'h00, 3'd2, 8'h00, 8'h00, 12'h23b},
		'{8'hc6, 8'h3c, 8'h00, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h23c}
	};
	aabu_unit dut (.core_clk, .rst, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.testInputZero, .testInputOne, .intLine, .busy);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	// Ready is sampled at the falling edge, where it has settled, and acted on at the next rising edge.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		logic [1:0] resp;
		int   n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk);
			aw = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			resp = bresp;
			@(posedge core_clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			n++;
		end while (!b && n < 40);
		bready <= 1'b0;
		if (!b) chk("write answer", 32'h0, 32'h1);
		else chk("write response", {30'h0, resp}, 32'h0);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		logic ar, r;
		logic [1:0] resp;
		int   n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk);
			ar = arvalid & arready;
			r = rvalid;
			resp = rresp;
			d = rdata;
			@(posedge core_clk);
			if (ar) arvalid <= 1'b0;
			n++;
		end while (!r && n < 40);
		rready <= 1'b0;
		if (!r) chk("read answer", 32'h0, 32'h1);
		else chk("read response", {30'h0, resp}, 32'h0);
	endtask : axr
	task automatic run_row(input aabu_row_t r);
		int n;
		testInputZero <= r.pins[0];
		testInputOne <= r.pins[1];
		intLine <= r.pins[2];
		axw(`AABU_ACC_OFF, {24'h0, r.acc});
		axw(`AABU_PSW_OFF, {24'h0, r.psw});
		axw(`AABU_PC_OFF, {20'h0, PC_START});
		axw(`AABU_WREG_OFF + {r.opc[2:0], 2'b00}, {24'h0, r.src});
		axw(`AABU_RAMD_OFF, {24'h0, r.src});
		axw(`AABU_PRD_OFF, {24'h0, r.src});
		axw(`AABU_OPC_OFF, {24'h0, r.opc});
		axw(`AABU_OPND_OFF, {24'h0, r.opnd});
		axw(`AABU_CTRL_OFF, 32'h1);
		@(negedge core_clk);
		chk("busy pin", {31'h0, busy}, 32'h1);
		n = 0;
		do begin
			axr(`AABU_STAT_OFF, rd);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
		chk($sformatf("idle op %h", r.opc), {31'h0, rd[0]}, 32'h0);
		axr(`AABU_ACC_OFF, rd);
		chk($sformatf("acc op %h", r.opc), rd, {24'h0, r.eAcc});
		axr(`AABU_PSW_OFF, rd);
		chk($sformatf("psw op %h", r.opc), rd & 32'hf8, {24'h0, r.ePsw & 8'hf8});
		axr(`AABU_PC_OFF, rd);
		chk($sformatf("pc op %h", r.opc), rd, {20'h0, r.ePc});
	endtask : run_row
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, testInputZero, testInputOne, intLine} = 8'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		awprot = 3'h0;
		arprot = 3'h0;
		wstrb = 4'hf;
		fails = 0;
		check_count = 0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		axr(`AABU_ACC_OFF, rd);
		chk("acc after reset", rd, {24'h0, `AABU_ACC_RST});
		axr(`AABU_PC_OFF, rd);
		chk("pc after reset", rd, {20'h0, `AABU_PC_RST});
		$display("reset test done");
		for (int i = 0; i < NROWS; i++) begin
			run_row(rows[i]);
		end
		$display("table test done");
		// The bank flag is set and cleared by instruction, then steers bit 11 of a direct jump.
		run_row('{8'hf5, 8'h00, 8'h00, 8'h00, 8'h00, 3'd0, 8'h00, 8'h08, 12'h206});
		run_row('{8'he5, 8'h00, 8'h00, 8'h08, 8'h00, 3'd0, 8'h00, 8'h00, 12'h206});
		run_row('{8'h64, 8'h9a, 8'h00, 8'h00, 8'h00, 3'd0, 8'h00, 8'h00, 12'h39a});
		$display("bank test done");
		run_row('{8'hec, 8'h40, 8'h11, 8'h00, 8'h01, 3'd0, 8'h11, 8'h00, 12'h207});
		axr(`AABU_WREG_OFF + 8'h10, rd);
		chk("count register", rd, 32'h0);
		$display("count-out test done");
		axw(8'h3c, 32'h5a);
		axr(8'h3c, rd);
		chk("unmapped read", rd, 32'h0);
		$display("unmapped test done");
		axw(`AABU_ACC_OFF, 32'h77);
		@(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		axr(`AABU_ACC_OFF, rd);
		chk("acc after second reset", rd, {24'h0, `AABU_ACC_RST});
		$display("second reset test done");
		finish_test();
	end
	// The full run needs a few thousand cycles; this limit leaves ample margin.
	initial begin
		#(20000 * 50);
		fails++;
		$display("[ERR] watchdog expected finish seen timeout");
		finish_test();
	end
endmodule : accumulator_alu_branch_unit_tb_top
